// ### hw/nfctam_pkg.sv
// Shared constants, types and helpers for the tag host address map
package nfctam_pkg;

    // Address map regions
    localparam int BUF_BYTES = 3000;
    localparam int BUF_AW = 12;
    localparam logic [15:0] BUF_LAST = 16'h0bb7;
    localparam logic [15:0] RSVD_GROW_START = 16'h0bb8;
    localparam logic [15:0] RSVD_GROW_END = 16'h3fff;
    localparam logic [15:0] RSVD_HIGH_START = 16'h4000;
    localparam logic [15:0] REG_BASE = 16'hffda;
    localparam int REG_COUNT = 19;

    // Register offsets
    localparam logic [15:0] OFF_CUSTOM_STATUS_WORD = 16'hffda;
    localparam logic [15:0] OFF_RESERVED_DC = 16'hffdc;
    localparam logic [15:0] OFF_WAIT_EXTENSION_REQUEST = 16'hffde;
    localparam logic [15:0] OFF_RESERVED_E0 = 16'hffe0;
    localparam logic [15:0] OFF_RESERVED_E2 = 16'hffe2;
    localparam logic [15:0] OFF_BUFFER_START_POINTER = 16'hffe4;
    localparam logic [15:0] OFF_FILE_OFFSET = 16'hffe6;
    localparam logic [15:0] OFF_FILE_BLOCK_LENGTH = 16'hffe8;
    localparam logic [15:0] OFF_HOST_RESPONSE = 16'hffea;
    localparam logic [15:0] OFF_FILE_IDENTIFIER = 16'hffec;
    localparam logic [15:0] OFF_VERSION = 16'hffee;
    localparam logic [15:0] OFF_LINK_WATCHDOG_CONTROL = 16'hfff0;
    localparam logic [15:0] OFF_CRC_START_ADDRESS = 16'hfff2;
    localparam logic [15:0] OFF_CRC_LENGTH = 16'hfff4;
    localparam logic [15:0] OFF_CRC_RESULT = 16'hfff6;
    localparam logic [15:0] OFF_INTERRUPT_FLAGS = 16'hfff8;
    localparam logic [15:0] OFF_INTERRUPT_ENABLE = 16'hfffa;
    localparam logic [15:0] OFF_STATUS = 16'hfffc;
    localparam logic [15:0] OFF_CONTROL = 16'hfffe;

    // Register reset value and status field positions
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_CMD_PENDING_BIT = 1;
    localparam int STAT_CRC_BUSY_BIT = 2;

    // Serial target address upper bits
    localparam logic [3:0] DEV_ADDR_HI = 4'h3;

    // CRC-16 CCITT
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // Link side wait before an extension request, in link clock cycles
    localparam int WTX_WAIT_DEF = 64;

    typedef enum logic [1:0] {RGN_BUF = 2'h0, RGN_RSVD = 2'h1, RGN_REG = 2'h2} nfctam_region_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_DEV = 7'h02, ST_AHI = 7'h04, ST_ALO = 7'h08,
        ST_WR = 7'h10, ST_RD = 7'h20, ST_IGN = 7'h40
    } nfctam_state_t;

    typedef struct packed {
        logic we;
        logic [BUF_AW-1:0] addr;
        logic [7:0] data;
    } nfctam_mem_wr_t;

    typedef struct packed {
        nfctam_state_t state;
        logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
        logic [2:0] strap_s1, strap_s2;
        logic [3:0] bit_cnt;
        logic [1:0] ack_stage;
        logic [7:0] shreg;
        logic sda_oe;
        logic [15:0] addr;
        nfctam_region_t start_rgn;
        logic [1:0] wcnt;
        logic pend_valid;
        logic [15:0] pend_addr;
        logic [7:0] pend_data;
        logic [REG_COUNT-1:0][15:0] regs;
        logic crc_busy, crc_rd;
        logic [15:0] crc_ptr, crc_left, crc_val;
        logic cmd_s1, cmd_s2, cmd_q, cmd_pending, resp_tog;
    } nfctam_core_t;

    typedef struct packed {
        logic cmd_q, cmd_tog, resp_s1, resp_s2, resp_q;
        logic waiting, wtx, ready;
        logic [15:0] cnt;
    } nfctam_rf_t;

    function automatic nfctam_region_t addr_region(input logic [15:0] a);
        if (a <= BUF_LAST) begin
            return RGN_BUF;
        end else if (a >= REG_BASE) begin
            return RGN_REG;
        end
        return RGN_RSVD;
    endfunction

    function automatic logic [4:0] reg_index(input logic [15:0] a);
        logic [15:0] d;
        d = a - REG_BASE;
        return d[5:1];
    endfunction

    function automatic logic [15:0] crc_ccitt_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            x = x[15] ? ({x[14:0], 1'b0} ^ CRC_POLY) : {x[14:0], 1'b0};
        end
        return x;
    endfunction

endpackage

// ### hw/nfctam_buffer_mem.sv
// Byte-wide data buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module nfctam_buffer_mem
    import nfctam_pkg::*;
#(
    parameter int DEPTH = BUF_BYTES,
    parameter int AW = BUF_AW
) (
    input wire logic clk_i,
    input wire nfctam_mem_wr_t wr_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    if (DEPTH > (1 << AW) || AW != BUF_AW) begin : g_bad_size
        $error("buffer depth does not fit the address width");
    end

    logic [7:0] mem [DEPTH];

    // Write port and registered read, zero outside the array
    always_ff @(posedge clk_i) begin
        if (wr_i.we && int'(wr_i.addr) < DEPTH) begin
            mem[wr_i.addr] <= wr_i.data;
        end
        rdata_o <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : 8'h00;
    end
endmodule
`default_nettype wire

// ### hw/nfctam_wtx_link.sv
// Link clock side: command arrival and wait time extension requests
`timescale 1ns/1ps
`default_nettype none
module nfctam_wtx_link
    import nfctam_pkg::*;
#(
    parameter int WAIT_CYCLES = WTX_WAIT_DEF
) (
    input wire logic rf_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_i,
    input wire logic resp_tog_i,
    output logic cmd_tog_o,
    output logic wtx_req_o,
    output logic resp_ready_o
);
    if (WAIT_CYCLES < 2 || WAIT_CYCLES > 65535) begin : g_bad_wait
        $error("wait cycles out of range");
    end

    localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYCLES - 1);

    nfctam_rf_t r, n;

    // Next state: response crossing, command capture, wait timer
    always_comb begin
        n = r;
        n.wtx = 1'b0;
        n.cmd_q = cmd_i;
        n.resp_s1 = resp_tog_i;
        n.resp_s2 = r.resp_s1;
        n.resp_q = r.resp_s2;
        if (r.resp_s2 != r.resp_q) begin
            n.waiting = 1'b0;
            n.ready = 1'b1;
        end else if (r.waiting) begin
            n.cnt = r.cnt + 16'h0001;
            if (r.cnt == WAIT_LAST) begin
                n.wtx = 1'b1;
                n.cnt = 16'h0000;
            end
        end
        if (cmd_i && !r.cmd_q) begin
            n.cmd_tog = ~r.cmd_tog;
            n.waiting = 1'b1;
            n.ready = 1'b0;
            n.cnt = 16'h0000;
        end
    end

    // State register
    always_ff @(posedge rf_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign cmd_tog_o = r.cmd_tog;
    assign wtx_req_o = r.wtx;
    assign resp_ready_o = r.ready;

    default clocking cb @(posedge rf_clk_i); endclocking
    default disable iff (!nrst_i);

    AST_WTX_AFTER_TIMEOUT: assert property (
        (r.waiting && r.cnt == WAIT_LAST && r.resp_s2 == r.resp_q && !(cmd_i && !r.cmd_q))
        |=> wtx_req_o && r.cnt == 16'h0000)
        else $error("extension request missing after wait time");
    AST_WTX_SINGLE_PULSE: assert property (
        wtx_req_o |=> !wtx_req_o)
        else $error("extension request longer than one cycle");
endmodule
`default_nettype wire

// ### hw/nfctam_top.sv
// Serial target port, address map, register bank and CRC engine of the tag
//
// Functional notes
// - One two-wire target port carries all accesses
// - Host reads and writes registers and buffer
// - Buffer holds 3000 bytes at 0x0000-0x0BB7
// - Region crossing drops writes, reads arbitrary
// - Growth and high spans are reserved
// - CRC result, length, start registers provided
// - Late answer sends wait extension request
// - Target address 0011 plus three straps
// - Write: address high, low, data, incrementing
// - Read: address, repeated start, until NACK
`timescale 1ns/1ps
`default_nettype none
module nfctam_top
    import nfctam_pkg::*;
#(
    parameter logic [15:0] VERSION_CODE = 16'h0101, // Arbitrary value
    parameter int WTX_WAIT_CYCLES = WTX_WAIT_DEF
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic [2:0] ADDR_STRAP_I,
    input wire logic RF_CLK_I,
    input wire logic RF_CMD_I,
    output logic RF_WTX_REQ_O,
    output logic RF_RESP_READY_O,
    output logic HOST_CMD_PENDING_O
);
    localparam logic [4:0] IDX_RSVD_DC = reg_index(OFF_RESERVED_DC);
    localparam logic [4:0] IDX_RSVD_E0 = reg_index(OFF_RESERVED_E0);
    localparam logic [4:0] IDX_RSVD_E2 = reg_index(OFF_RESERVED_E2);
    localparam logic [4:0] IDX_HOST_RESP = reg_index(OFF_HOST_RESPONSE);
    localparam logic [4:0] IDX_VERSION = reg_index(OFF_VERSION);
    localparam logic [4:0] IDX_CRC_START = reg_index(OFF_CRC_START_ADDRESS);
    localparam logic [4:0] IDX_CRC_LEN = reg_index(OFF_CRC_LENGTH);
    localparam logic [4:0] IDX_CRC_RES = reg_index(OFF_CRC_RESULT);
    localparam logic [4:0] IDX_STATUS = reg_index(OFF_STATUS);

    nfctam_core_t r, n;
    nfctam_mem_wr_t mem_wr;
    logic [BUF_AW-1:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic cmd_tog_rf;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic commit, ld, reg_we;
    logic [15:0] c_addr;
    logic [7:0] c_data, bit_in, rd_byte;
    logic [4:0] c_idx;
    logic [15:0] crc_len_new;

    function automatic logic reg_reserved(input logic [4:0] idx);
        return idx == IDX_RSVD_DC || idx == IDX_RSVD_E0 || idx == IDX_RSVD_E2;
    endfunction

    function automatic logic reg_writable(input logic [4:0] idx);
        return !reg_reserved(idx) && idx != IDX_VERSION && idx != IDX_CRC_RES
            && idx != IDX_STATUS;
    endfunction

    // Byte seen by the host at a given address
    function automatic logic [7:0] read_byte(input logic [15:0] a, input nfctam_core_t s,
                                             input logic [7:0] mdata);
        logic [15:0] word;
        logic [4:0] idx;
        idx = reg_index(a);
        word = s.regs[idx];
        if (idx == IDX_VERSION) begin
            word = VERSION_CODE;
        end else if (idx == IDX_STATUS) begin
            word = REG_RESET;
            word[STAT_READY_BIT] = 1'b1;
            word[STAT_CMD_PENDING_BIT] = s.cmd_pending;
            word[STAT_CRC_BUSY_BIT] = s.crc_busy;
        end else if (reg_reserved(idx)) begin
            word = REG_RESET;
        end
        if (addr_region(a) != s.start_rgn) begin
            return 8'hff;
        end else if (addr_region(a) == RGN_BUF) begin
            return mdata;
        end else if (addr_region(a) == RGN_RSVD) begin
            return 8'h00;
        end
        return a[0] ? word[7:0] : word[15:8];
    endfunction

    // Bus conditions from the synchronised lines
    assign scl_rise = r.scl_s2 && !r.scl_q;
    assign scl_fall = !r.scl_s2 && r.scl_q;
    assign start_c = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
    assign stop_c = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
    assign bit_in = {r.shreg[6:0], r.sda_s2};
    assign rd_byte = read_byte(r.addr, r, mem_rdata);
    assign mem_raddr = (r.state == ST_IDLE) ? r.crc_ptr[BUF_AW-1:0] : r.addr[BUF_AW-1:0];

    // Next state of the whole core
    always_comb begin
        n = r;
        mem_wr = '0;
        commit = 1'b0;
        ld = 1'b0;
        reg_we = 1'b0;
        c_addr = r.pend_addr;
        c_data = r.pend_data;
        c_idx = reg_index(r.pend_addr);
        crc_len_new = {r.regs[IDX_CRC_LEN][15:8], r.pend_data};
        n.scl_s1 = SCL_I;
        n.scl_s2 = r.scl_s1;
        n.scl_q = r.scl_s2;
        n.sda_s1 = SDA_I;
        n.sda_s2 = r.sda_s1;
        n.sda_q = r.sda_s2;
        n.strap_s1 = ADDR_STRAP_I;
        n.strap_s2 = r.strap_s1;
        n.cmd_s1 = cmd_tog_rf;
        n.cmd_s2 = r.cmd_s1;
        n.cmd_q = r.cmd_s2;
        if (start_c || stop_c) begin
            // last byte kept only after two
            commit = r.pend_valid && r.wcnt == 2'h2;
            n.pend_valid = 1'b0;
            n.sda_oe = 1'b0;
            n.ack_stage = 2'h0;
            n.bit_cnt = 4'h0;
            n.state = start_c ? ST_DEV : ST_IDLE;
        end else if (scl_rise) begin
            case (r.state)
                ST_DEV, ST_AHI, ST_ALO, ST_WR: begin
                    if (r.ack_stage == 2'h0) begin
                        n.shreg = bit_in;
                        n.bit_cnt = r.bit_cnt + 4'h1;
                        if (r.bit_cnt == 4'h7) begin
                            n.bit_cnt = 4'h0;
                            n.ack_stage = 2'h1;
                            case (r.state)
                                ST_DEV: begin
                                    if (bit_in[7:1] != {DEV_ADDR_HI, r.strap_s2}) begin
                                        n.state = ST_IGN;
                                        n.ack_stage = 2'h0;
                                    end else begin
                                        n.state = bit_in[0] ? ST_RD : ST_AHI;
                                    end
                                end
                                ST_AHI: begin
                                    n.addr[15:8] = bit_in;
                                    n.state = ST_ALO;
                                end
                                ST_ALO: begin
                                    n.addr[7:0] = bit_in;
                                    n.start_rgn = addr_region({r.addr[15:8], bit_in});
                                    n.wcnt = 2'h0;
                                    n.state = ST_WR;
                                end
                                default: begin
                                    commit = r.pend_valid;
                                    n.pend_valid = 1'b1;
                                    n.pend_addr = r.addr;
                                    n.pend_data = bit_in;
                                    n.addr = r.addr + 16'h0001;
                                    if (r.wcnt != 2'h2) begin
                                        n.wcnt = r.wcnt + 2'h1;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_RD: begin
                    if (r.bit_cnt == 4'h9) begin
                        if (r.sda_s2) begin
                            n.state = ST_IGN;
                        end else begin
                            n.bit_cnt = 4'ha;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            if (r.ack_stage == 2'h1) begin
                n.sda_oe = 1'b1;
                n.ack_stage = 2'h2;
            end else if (r.ack_stage == 2'h2) begin
                n.sda_oe = 1'b0;
                n.ack_stage = 2'h0;
                ld = (r.state == ST_RD);
            end else if (r.state == ST_RD) begin
                if (r.bit_cnt == 4'ha) begin
                    ld = 1'b1;
                end else if (r.bit_cnt < 4'h8) begin
                    n.sda_oe = ~r.shreg[7];
                    n.shreg = {r.shreg[6:0], 1'b0};
                    n.bit_cnt = r.bit_cnt + 4'h1;
                end else if (r.bit_cnt == 4'h8) begin
                    n.sda_oe = 1'b0;
                    n.bit_cnt = 4'h9;
                end
            end
            if (ld) begin
                n.sda_oe = ~rd_byte[7];
                n.shreg = {rd_byte[6:0], 1'b0};
                n.bit_cnt = 4'h1;
                n.addr = r.addr + 16'h0001;
            end
        end
        // writes outside the start region dropped
        if (commit && addr_region(c_addr) == r.start_rgn) begin
            if (r.start_rgn == RGN_BUF) begin
                mem_wr = '{we: 1'b1, addr: c_addr[BUF_AW-1:0], data: c_data};
            end else if (r.start_rgn == RGN_REG && reg_writable(c_idx)) begin
                reg_we = 1'b1;
                if (c_addr[0]) begin
                    n.regs[c_idx][7:0] = c_data;
                end else begin
                    n.regs[c_idx][15:8] = c_data;
                end
                if (c_addr[0] && c_idx == IDX_HOST_RESP) begin
                    n.resp_tog = ~r.resp_tog;
                    n.cmd_pending = 1'b0;
                end
                if (c_addr[0] && c_idx == IDX_CRC_LEN) begin
                    n.crc_busy = crc_len_new != 16'h0000;
                    n.crc_rd = 1'b0;
                    n.crc_ptr = r.regs[IDX_CRC_START];
                    n.crc_left = crc_len_new;
                    n.crc_val = CRC_INIT;
                    n.regs[IDX_CRC_RES] = CRC_INIT;
                end
            end
        end
        // CRC walk while the bus is idle
        if (r.crc_busy && r.state == ST_IDLE) begin
            n.crc_rd = ~r.crc_rd;
            if (r.crc_rd) begin
                n.crc_val = crc_ccitt_byte(r.crc_val, mem_rdata);
                n.crc_ptr = r.crc_ptr + 16'h0001;
                n.crc_left = r.crc_left - 16'h0001;
                if (r.crc_left == 16'h0001) begin
                    n.crc_busy = 1'b0;
                    n.regs[IDX_CRC_RES] = crc_ccitt_byte(r.crc_val, mem_rdata);
                end
            end
        end else if (r.state != ST_IDLE) begin
            n.crc_rd = 1'b0;
        end
        // new reader command, set beats clear
        if (r.cmd_s2 != r.cmd_q) begin
            n.cmd_pending = 1'b1;
        end
    end

    // State register
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            r <= '{state: ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_q: 1'b1, start_rgn: RGN_BUF,
                   crc_val: CRC_INIT, default: '0};
        end else begin
            r <= n;
        end
    end

    nfctam_buffer_mem #(.DEPTH(BUF_BYTES), .AW(BUF_AW)) u_mem (
        .clk_i(REF_CLK_I),
        .wr_i(mem_wr),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    nfctam_wtx_link #(.WAIT_CYCLES(WTX_WAIT_CYCLES)) u_link (
        .rf_clk_i(RF_CLK_I),
        .nrst_i(NRST_I),
        .cmd_i(RF_CMD_I),
        .resp_tog_i(r.resp_tog),
        .cmd_tog_o(cmd_tog_rf),
        .wtx_req_o(RF_WTX_REQ_O),
        .resp_ready_o(RF_RESP_READY_O)
    );

    // Open-drain data line: only ever pulled low
    assign SDA_O = 1'b0;
    assign SDA_OE_O = r.sda_oe;
    assign HOST_CMD_PENDING_O = r.cmd_pending;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_master_nack;
        r.state == ST_RD && scl_rise && r.bit_cnt == 4'h9 && r.sda_s2 && !start_c;
    endsequence

    sequence s_released_twice;
        !SDA_OE_O [*2];
    endsequence

    AST_BUF_WRITE_RANGE: assert property (
        mem_wr.we |-> int'(mem_wr.addr) < BUF_BYTES && r.start_rgn == RGN_BUF)
        else $error("buffer write outside the buffer");
    AST_CROSS_NO_WRITE: assert property (
        (commit && addr_region(c_addr) != r.start_rgn) |-> !mem_wr.we && !reg_we)
        else $error("write crossed a region boundary");
    AST_SINGLE_BYTE_DROP: assert property (
        (stop_c && r.pend_valid && r.wcnt == 2'h1) |-> !mem_wr.we && !reg_we)
        else $error("single data byte write took effect");
    AST_ADDR_INC: assert property (
        (r.state == ST_WR && scl_rise && r.bit_cnt == 4'h7 && r.ack_stage == 2'h0
         && !start_c && !stop_c) |=> r.addr == $past(r.addr) + 16'h0001 && r.pend_valid)
        else $error("write address did not advance");
    AST_NACK_RELEASES: assert property (
        s_master_nack |=> r.state == ST_IGN ##0 s_released_twice)
        else $error("data line held after controller NACK");
    AST_FOREIGN_QUIET: assert property (
        r.state == ST_IGN |-> !SDA_OE_O)
        else $error("line driven while not addressed");
    AST_RSVD_READ_ZERO: assert property (
        (ld && addr_region(r.addr) == RGN_REG && r.start_rgn == RGN_REG
         && reg_reserved(reg_index(r.addr))) |=> SDA_OE_O && r.shreg == 8'h00)
        else $error("reserved register read not zero");
    AST_CRC_STARTS: assert property (
        (reg_we && c_addr[0] && c_idx == IDX_CRC_LEN && crc_len_new != 16'h0000)
        |=> r.crc_busy && r.crc_left == $past(crc_len_new))
        else $error("CRC did not start on length write");
endmodule
`default_nettype wire

// ### testbench/nfctam_host_model.sv
// Two-wire bus controller model acting as the host
`timescale 1ns/1ps
`default_nettype none
module nfctam_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic [6:0] dev = 7'h18;
    // Lines released at start
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Wait core cycles, move just after the edge
    task automatic hw(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Start or repeated start
    task automatic sta();
        sda_o = 1'b1;
        hw(4);
        scl_o = 1'b1;
        hw(8);
        sda_o = 1'b0;
        hw(8);
        scl_o = 1'b0;
        hw(4);
    endtask
    task automatic sto();
        sda_o = 1'b0;
        hw(4);
        scl_o = 1'b1;
        hw(8);
        sda_o = 1'b1;
        hw(8);
    endtask
    // One bit, line sampled mid high phase
    task automatic bt(input logic b, output logic r);
        sda_o = b;
        hw(4);
        scl_o = 1'b1;
        hw(4);
        r = sda_i;
        hw(4);
        scl_o = 1'b0;
        hw(4);
    endtask
    task automatic tx(input logic [7:0] b, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bt(b[i], r);
        bt(1'b1, r);
        a = ~r;
    endtask
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        bt(last, r);
    endtask
    task automatic hdr(input logic [15:0] adr, output logic a);
        logic x;
        sta();
        tx({dev, 1'b0}, a);
        tx(adr[15:8], x);
        tx(adr[7:0], x);
    endtask
    // write n bytes, first byte highest
    task automatic wr(input logic [15:0] adr, input logic [31:0] d, input int n, output logic a);
        logic x;
        hdr(adr, a);
        for (int i = n - 1; i >= 0; i--) tx(d[8*i+:8], x);
        sto();
    endtask
    // read n bytes, refuse the last
    task automatic rd(input logic [15:0] adr, input int n, output logic [31:0] v);
        logic a;
        v = 32'h0;
        hdr(adr, a);
        sta();
        tx({dev, 1'b1}, a);
        for (int i = n - 1; i >= 0; i--) rx(i == 0, v[8*i+:8]);
        sto();
    endtask
endmodule
`default_nettype wire

// ### testbench/nfc_tag_host_address_map_tb_top.sv
// Self-checking bench for the tag host address map
`timescale 1ns/1ps
`default_nettype none
module nfc_tag_host_address_map_tb_top;
    logic clk = 1'b0, rf_clk = 1'b0, nrst = 1'b0, rf_cmd = 1'b0, a;
    logic [2:0] strap = 3'h0;
    logic [31:0] v;
    wire logic scl, sda_h, sda_o, sda_oe, wtx, rdy, pend;
    wire logic sda = sda_h & (~sda_oe | sda_o);
    int fails = 0, checks_done = 0, wtx_n = 0, n0;
    initial forever #25 clk = ~clk;
    initial #3 forever #7.5 rf_clk = ~rf_clk;
    // Pulses counted mid-cycle, away from the edge that launches them
    always @(negedge rf_clk) if (wtx === 1'b1) wtx_n <= wtx_n + 1;
    nfctam_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
    nfctam_top #(.VERSION_CODE(16'h0101), .WTX_WAIT_CYCLES(4)) dut (.REF_CLK_I(clk),
        .NRST_I(nrst), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_STRAP_I(strap), .RF_CLK_I(rf_clk),
        .RF_CMD_I(rf_cmd), .RF_WTX_REQ_O(wtx), .RF_RESP_READY_O(rdy), .HOST_CMD_PENDING_O(pend));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic t_buf();
        host.wr(16'h0bb6, 32'h11223344, 4, a);
        host.rd(16'h0bb6, 4, v);
        chk(v, 32'h1122ffff);
        host.rd(16'h0bb8, 2, v);
        chk(v, 32'h0);
        $display("t_buf done");
    endtask
    task automatic t_reg();
        host.wr(16'hfffe, 32'h0016, 2, a);
        host.rd(16'hfffe, 2, v);
        chk(v, 32'h0016);
        host.wr(16'hffdc, 32'hbeef, 2, a);
        host.rd(16'hffdc, 2, v);
        chk(v, 32'h0);
        host.wr(16'hffda, 32'h00aa, 1, a);
        host.rd(16'hffda, 2, v);
        chk(v, 32'h0);
        host.wr(16'hffee, 32'h1234, 2, a);
        host.rd(16'hffee, 2, v);
        chk(v, 32'h0101);
        host.rd(16'hfffc, 2, v);
        chk(v, 32'h0001);
        $display("t_reg done");
    endtask
    task automatic t_crc();
        host.wr(16'h0000, 32'h313233, 3, a);
        host.wr(16'h0003, 32'h343536, 3, a);
        host.wr(16'h0006, 32'h373839, 3, a);
        host.wr(16'hfff2, 32'h00000009, 4, a);
        host.hw(40);
        host.rd(16'hfff6, 2, v);
        chk(v, 32'h29b1);
        $display("t_crc done");
    endtask
    task automatic t_addr();
        host.dev = 7'h19;
        host.wr(16'hffe4, 32'h1234, 2, a);
        chk({31'h0, a}, 32'h0);
        strap = 3'h1;
        host.wr(16'hffe4, 32'h1234, 2, a);
        chk({31'h0, a}, 32'h1);
        host.rd(16'hffe4, 2, v);
        chk(v, 32'h1234);
        $display("t_addr done");
    endtask
    task automatic t_link();
        @(posedge rf_clk) #1 rf_cmd = 1'b1;
        for (int i = 0; i < 50 && pend !== 1'b1; i++) @(negedge clk);
        chk({31'h0, pend}, 32'h1);
        if (fails != 0) close_out();
        repeat (12) @(posedge rf_clk);
        chk({31'h0, wtx_n >= 2}, 32'h1);
        host.wr(16'hffea, 32'h0001, 2, a);
        for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge rf_clk);
        chk({31'h0, rdy}, 32'h1);
        chk({31'h0, pend}, 32'h0);
        n0 = wtx_n;
        repeat (12) @(posedge rf_clk);
        chk(wtx_n, n0);
        $display("t_link done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        host.hw(4);
        t_buf();
        t_reg();
        t_crc();
        t_addr();
        t_link();
        close_out();
    end
endmodule
`default_nettype wire
